// ==== verilog/ufc_defs.svh ====
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// register port widths
`define UFC_ADDR_W 8
`define UFC_DATA_W 8
// number of switch ports covered by a port map
`define UFC_NPORTS 5

// register byte offsets
`define UFC_OFS_MCAST 8'h84
`define UFC_OFS_VID 8'h85
`define UFC_OFS_SELF 8'h86
`define UFC_OFS_RATE 8'h87

// field positions
`define UFC_EN_BIT 5
`define UFC_MAP_MSB 4
`define UFC_MAP_LSB 0
`define UFC_SELF_BIT 6
`define UFC_PER_MSB 5
`define UFC_PER_LSB 4
`define UFC_QMODE_BIT 3
`define UFC_PSRC_BIT 2

// reset values, reserved bits included
`define UFC_RST_MCAST 8'h40
`define UFC_RST_VID 8'h00
`define UFC_RST_SELF 8'h00
`define UFC_RST_RATE 8'h10

// writable bit masks, reserved bits excluded
`define UFC_WR_MCAST 8'h3F
`define UFC_WR_VID 8'h3F
`define UFC_WR_SELF 8'h7F
`define UFC_WR_RATE 8'h3C

// window period codes
`define UFC_PER_SHORT 2'b00
`define UFC_PER_MID 2'b01

// timing: clock rate and window lengths
`define UFC_CLK_KHZ 250000
`define UFC_WIN_SHORT_MS 16
`define UFC_WIN_MID_MS 64
`define UFC_WIN_LONG_MS 256

`endif

// ==== verilog/ufc_pkg.sv ====
package ufc_pkg;

  // one-hot choice of rate measurement window
  typedef enum logic [2:0] {
    UFC_WIN_SHORT = 3'b001,
    UFC_WIN_MID = 3'b010,
    UFC_WIN_LONG = 3'b100
  } ufc_win_t;

  // the four control registers
  typedef struct packed {
    logic [7:0] mcast;
    logic [7:0] vid;
    logic [7:0] self_ipmc;
    logic [7:0] rate;
  } ufc_regs_t;

  // whole state of the top module
  typedef struct packed {
    ufc_regs_t regs;
    logic [7:0] rd_data;
    logic dec_valid;
    logic [4:0] dec_mask;
    logic dec_drop;
    logic [4:0] dec_tag;
  } ufc_top_st_t;

  // whole state of the window timer
  typedef struct packed {
    logic [31:0] cnt;
    ufc_win_t sel;
    logic tick;
  } ufc_win_st_t;

endpackage

// ==== verilog/ufc_mask_pick.sv ====
`timescale 1ns/10ps
`include "ufc_defs.svh"

// one special-forwarding rule: enable bit plus port map
module ufc_mask_pick
  import ufc_pkg::*;
#(
  parameter int NPORTS = `UFC_NPORTS
) (
  input wire logic hit_i,
  input wire logic [7:0] ctrl_i,
  output logic use_o,
  output logic [NPORTS-1:0] mask_o
);

  // rule applies only when the frame class matches and it is enabled
  always_comb begin
    use_o = hit_i & ctrl_i[`UFC_EN_BIT];
    // map bit n selects port n+1; zero map means filter
    mask_o = ctrl_i[NPORTS-1:0];
  end

endmodule

// ==== verilog/ufc_win_timer.sv ====
`timescale 1ns/10ps
`include "ufc_defs.svh"

// ingress rate window timer, one-cycle tick per window
module ufc_win_timer
  import ufc_pkg::*;
#(
  parameter int SHORT_CYC = `UFC_WIN_SHORT_MS * `UFC_CLK_KHZ,
  parameter int MID_CYC = `UFC_WIN_MID_MS * `UFC_CLK_KHZ,
  parameter int LONG_CYC = `UFC_WIN_LONG_MS * `UFC_CLK_KHZ
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ufc_win_t sel_i,
  output logic tick_o
);

  ufc_win_st_t st_ff; // registered state
  ufc_win_st_t nxt_st; // next state

  // window length in cycles for a selection
  function automatic logic [31:0] lim_of(input ufc_win_t s);
    case (s)
      UFC_WIN_SHORT: lim_of = 32'(SHORT_CYC);
      UFC_WIN_MID: lim_of = 32'(MID_CYC);
      default: lim_of = 32'(LONG_CYC);
    endcase
  endfunction

  // count cycles, restart on a new selection
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sel = sel_i;
    nxt_st.tick = 1'b0;
    if (sel_i != st_ff.sel) begin
      // new window length: begin a fresh window
      nxt_st.cnt = 32'h0000_0000;
    end else if (st_ff.cnt >= lim_of(st_ff.sel) - 32'h0000_0001) begin
      // last cycle of the window
      nxt_st.cnt = 32'h0000_0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= '{cnt: 32'h0000_0000, sel: UFC_WIN_MID, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

// ==== verilog/ufc_top.sv ====
`timescale 1ns/10ps
`include "ufc_defs.svh"

// Behaviour
// - unknown multicast map: zero drops, bits select
// - multicast map used only when enabled, non-IP
// - unknown VLAN handling enabled by bit five
// - unknown VLAN port mask in bits four..zero
// - self-address filter enabled by bit six
// - self filter compares own MAC at egress
// - unknown IP multicast enabled by bit five
// - unknown IP multicast mask, zero filters
// - rate window 16, 64 or 256 ms
// - bit three picks port or queue limiting
// - bit two: tag insertion per source port
// - otherwise each egress port's own insert bit
module ufc_top
  import ufc_pkg::*;
#(
  parameter int NPORTS = `UFC_NPORTS,
  parameter int WIN_SHORT_CYC = `UFC_WIN_SHORT_MS * `UFC_CLK_KHZ,
  parameter int WIN_MID_CYC = `UFC_WIN_MID_MS * `UFC_CLK_KHZ,
  parameter int WIN_LONG_CYC = `UFC_WIN_LONG_MS * `UFC_CLK_KHZ
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // frame query from the lookup engine
  input wire logic req_valid_i,
  input wire logic req_unknown_mcast_i,
  input wire logic req_ip_mcast_i,
  input wire logic req_unknown_vid_i,
  input wire logic [47:0] req_dst_mac_i,
  input wire logic [2:0] req_src_port_i,
  input wire logic [NPORTS-1:0] req_lut_mask_i,
  // own MAC address from its own registers
  input wire logic [47:0] self_mac_i,
  // per-source insertion selections, source s at [s*NPORTS +: NPORTS]
  input wire logic [NPORTS*NPORTS-1:0] src_tag_sel_i,
  // per-egress-port insert bit of each port's first control register
  input wire logic [NPORTS-1:0] port_tag_ins_i,
  // decision answer
  output logic dec_valid_o,
  output logic [NPORTS-1:0] dec_port_mask_o,
  output logic dec_drop_o,
  output logic [NPORTS-1:0] dec_tag_insert_o,
  // configuration for the rate limiter
  output logic queue_rate_mode_o,
  output logic rate_window_tick_o
);

  ufc_top_st_t st_ff; // registered state
  ufc_top_st_t nxt_st; // next state

  // per-rule results from the map pickers
  logic mc_use; // unknown multicast rule applies
  logic [NPORTS-1:0] mc_mask; // its port map
  logic vid_use; // unknown VLAN rule applies
  logic [NPORTS-1:0] vid_mask; // its port map
  logic ipmc_use; // unknown IP multicast rule applies
  logic [NPORTS-1:0] ipmc_mask; // its port map
  logic self_hit; // destination is our own address
  ufc_win_t win_sel; // decoded window choice

  // merge a write into a register, reserved bits kept
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] wd,
                                       input logic [7:0] wmask);
    merge = (cur & ~wmask) | (wd & wmask);
  endfunction

  // plain non-IP multicast with unknown destination
  // IP multicast frames are left to the IP rule
  ufc_mask_pick #(
    .NPORTS(NPORTS)
  ) u_pick_mc (
    .hit_i(req_unknown_mcast_i & ~req_ip_mcast_i),
    .ctrl_i(st_ff.regs.mcast),
    .use_o(mc_use),
    .mask_o(mc_mask)
  );

  // unknown VLAN rule, enabled by its bit
  // takes its mask from the low five bits
  ufc_mask_pick #(
    .NPORTS(NPORTS)
  ) u_pick_vid (
    .hit_i(req_unknown_vid_i),
    .ctrl_i(st_ff.regs.vid),
    .use_o(vid_use),
    .mask_o(vid_mask)
  );

  // unknown IP multicast rule with enable
  ufc_mask_pick #(
    .NPORTS(NPORTS)
  ) u_pick_ipmc (
    .hit_i(req_unknown_mcast_i & req_ip_mcast_i),
    .ctrl_i(st_ff.regs.self_ipmc),
    .use_o(ipmc_use),
    .mask_o(ipmc_mask)
  );

  // compare destination with our own address
  assign self_hit = (req_dst_mac_i == self_mac_i);

  // decode window period, 1x means longest
  always_comb begin
    case (st_ff.regs.rate[`UFC_PER_MSB:`UFC_PER_LSB])
      `UFC_PER_SHORT: win_sel = UFC_WIN_SHORT;
      `UFC_PER_MID: win_sel = UFC_WIN_MID;
      default: win_sel = UFC_WIN_LONG;
    endcase
  end

  // window timer feeding the ingress rate limiter
  ufc_win_timer #(
    .SHORT_CYC(WIN_SHORT_CYC),
    .MID_CYC(WIN_MID_CYC),
    .LONG_CYC(WIN_LONG_CYC)
  ) u_win (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sel_i(win_sel),
    .tick_o(rate_window_tick_o)
  );

  // register access and forwarding decision
  always_comb begin
    logic [NPORTS-1:0] mask; // chosen egress ports
    logic [NPORTS-1:0] tag; // chosen insertion per egress
    mask = '0;
    tag = '0;
    nxt_st = st_ff;

    // register writes; unmapped offsets are ignored
    if (wr_i) begin
      // reserved bits never change on write
      case (addr_i)
        `UFC_OFS_MCAST: begin
          nxt_st.regs.mcast = merge(st_ff.regs.mcast, wr_data_i, `UFC_WR_MCAST);
        end
        `UFC_OFS_VID: begin
          nxt_st.regs.vid = merge(st_ff.regs.vid, wr_data_i, `UFC_WR_VID);
        end
        `UFC_OFS_SELF: begin
          nxt_st.regs.self_ipmc = merge(st_ff.regs.self_ipmc, wr_data_i, `UFC_WR_SELF);
        end
        `UFC_OFS_RATE: begin
          nxt_st.regs.rate = merge(st_ff.regs.rate, wr_data_i, `UFC_WR_RATE);
        end
        default: begin
          // nothing mapped here
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    nxt_st.rd_data = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `UFC_OFS_MCAST: nxt_st.rd_data = st_ff.regs.mcast;
        `UFC_OFS_VID: nxt_st.rd_data = st_ff.regs.vid;
        `UFC_OFS_SELF: nxt_st.rd_data = st_ff.regs.self_ipmc;
        `UFC_OFS_RATE: nxt_st.rd_data = st_ff.regs.rate;
        // unmapped reads return zero
        default: nxt_st.rd_data = 8'h00;
      endcase
    end

    // forwarding: VLAN rule first, then IP, then plain multicast
    // unknown VLAN frames go to their own map
    if (vid_use) begin
      mask = vid_mask;
    // unknown IP multicast through its map
    end else if (ipmc_use) begin
      mask = ipmc_mask;
    end else if (mc_use) begin
      mask = mc_mask;
    end else begin
      // rules off: the lookup engine's own result
      mask = req_lut_mask_i;
    end

    // filter acts on every egress port
    if (st_ff.regs.self_ipmc[`UFC_SELF_BIT] && self_hit) begin
      mask = '0;
    end

    // per-source selection row of the ingress port
    if (st_ff.regs.rate[`UFC_PSRC_BIT]) begin
      if (req_src_port_i < 3'(NPORTS)) begin
        tag = src_tag_sel_i[req_src_port_i * NPORTS +: NPORTS];
      end else begin
        // no such source port: insert nothing
        tag = '0;
      end
    end else begin
      // each egress port's own insert bit
      tag = port_tag_ins_i;
    end

    // answer one cycle after the query, for one cycle
    nxt_st.dec_valid = req_valid_i;
    if (req_valid_i) begin
      // mask bit n is port n+1, passed as is
      nxt_st.dec_mask = mask;
      // an empty mask means the frame is dropped
      nxt_st.dec_drop = (mask == '0);
      nxt_st.dec_tag = tag & mask;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff.regs.mcast <= `UFC_RST_MCAST;
      st_ff.regs.vid <= `UFC_RST_VID;
      st_ff.regs.self_ipmc <= `UFC_RST_SELF;
      st_ff.regs.rate <= `UFC_RST_RATE;
      st_ff.rd_data <= 8'h00;
      st_ff.dec_valid <= 1'b0;
      st_ff.dec_mask <= '0;
      st_ff.dec_drop <= 1'b0;
      st_ff.dec_tag <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign rd_data_o = st_ff.rd_data;
  assign dec_valid_o = st_ff.dec_valid;
  assign dec_port_mask_o = st_ff.dec_mask;
  assign dec_drop_o = st_ff.dec_drop;
  assign dec_tag_insert_o = st_ff.dec_tag;
  // zero limits per port, one per queue
  assign queue_rate_mode_o = st_ff.regs.rate[`UFC_QMODE_BIT];

endmodule

// ==== verif/ufc_top_sva.sv ====
`timescale 1ns/10ps
// watches register port and decision answer
module ufc_top_chk
  import ufc_pkg::*;
#(
  parameter int NPORTS = 5
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic req_valid_i,
  input wire logic dec_valid_o,
  input wire logic [NPORTS-1:0] dec_port_mask_o,
  input wire logic dec_drop_o,
  input wire logic [NPORTS-1:0] dec_tag_insert_o,
  input wire logic queue_rate_mode_o,
  input wire logic rate_window_tick_o
);
  // one clock domain, reset disables all
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ANS: assert property (req_valid_i |=> dec_valid_o)
    else $error("answer missing after query");
  AST_NO_ANS: assert property (!req_valid_i |=> !dec_valid_o)
    else $error("answer without query");
  AST_DROP: assert property (dec_valid_o |-> dec_drop_o == (dec_port_mask_o == '0))
    else $error("drop flag disagrees with mask");
  AST_TAG_IN_MASK: assert property (dec_valid_o |-> (dec_tag_insert_o & ~dec_port_mask_o) == '0)
    else $error("tag outside egress mask");
  AST_HOLD: assert property (!dec_valid_o && !$past(rst_i) |-> $stable(dec_port_mask_o))
    else $error("mask changed without answer");
  AST_QMODE: assert property (wr_i && addr_i == 8'h87 |=> queue_rate_mode_o == $past(wr_data_i[3]))
    else $error("queue mode not following write");
  AST_UNMAPPED: assert property (rd_i && (addr_i < 8'h84 || addr_i > 8'h87) |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RSV_RATE: assert property (rd_i && addr_i == 8'h87 |=> rd_data_o[7:6] == 2'b00 && rd_data_o[1:0] == 2'b00)
    else $error("reserved rate bits nonzero");
  AST_RSV_SELF: assert property (rd_i && addr_i == 8'h86 |=> !rd_data_o[7])
    else $error("reserved self bit set");
  AST_TICK_GAP: assert property (rate_window_tick_o |=> !rate_window_tick_o [*8])
    else $error("window ticks too close");
endmodule
bind ufc_top ufc_top_chk #(.NPORTS(NPORTS)) u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .req_valid_i(req_valid_i), .dec_valid_o(dec_valid_o), .dec_port_mask_o(dec_port_mask_o),
  .dec_drop_o(dec_drop_o), .dec_tag_insert_o(dec_tag_insert_o),
  .queue_rate_mode_o(queue_rate_mode_o), .rate_window_tick_o(rate_window_tick_o));

// ==== verif/ufc_top_tb.sv ====
`timescale 1ns/10ps
// drives register port and frame queries
module ufc_top_tb import ufc_pkg::*;;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rv = 0, mc = 0, ip = 0, uv = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic [47:0] dst = 48'h0000_0000_0000, mac = 48'h0000_1234_5678;
  logic [2:0] src = 3'h0;
  logic [4:0] lut = 5'h0A, pti = 5'h15, msk, tag;
  // source 2 row is 01110
  logic [24:0] sel = 25'h000_3800;
  logic dv, drop, qm, tick;
  int err_total = 0, cmp_count = 0;
  ufc_top #(.WIN_SHORT_CYC(20), .WIN_MID_CYC(40), .WIN_LONG_CYC(80)) dut (.ref_clk_i(clk),
    .rst_i(rst), .addr_i(addr), .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
    .req_valid_i(rv), .req_unknown_mcast_i(mc), .req_ip_mcast_i(ip), .req_unknown_vid_i(uv),
    .req_dst_mac_i(dst), .req_src_port_i(src), .req_lut_mask_i(lut), .self_mac_i(mac),
    .src_tag_sel_i(sel), .port_tag_ins_i(pti), .dec_valid_o(dv), .dec_port_mask_o(msk),
    .dec_drop_o(drop), .dec_tag_insert_o(tag), .queue_rate_mode_o(qm),
    .rate_window_tick_o(tick));
  // 250 MHz clock
  initial forever #2 clk = ~clk;
  // compare and count
  task chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // one-cycle write strobe
  task wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read, data stands the cycle after
  task rreg(logic [7:0] a, logic [7:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdat);
  endtask
  // query with flags {mcast, ip, vid}, answer one cycle later
  task query(logic [2:0] f, logic [47:0] d, logic [4:0] e);
    @(posedge clk);
    {mc, ip, uv} <= f;
    dst <= d;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    #1 chk("valid", 8'h01, {7'h00, dv});
    chk("mask", {3'h0, e}, {3'h0, msk});
    chk("drop", {7'h00, e == 5'h00}, {7'h00, drop});
  endtask
  // reset values and unmapped read
  task t_reset;
    rreg(8'h84, 8'h40, "mcast");
    rreg(8'h85, 8'h00, "vid");
    rreg(8'h86, 8'h00, "self");
    rreg(8'h87, 8'h10, "rate");
    rreg(8'h88, 8'h00, "unmapped");
    chk("qmode", 8'h00, {7'h00, qm});
    $display("t_reset done");
  endtask
  // reserved bits ignore writes
  task t_rsv;
    wreg(8'h84, 8'hFF);
    wreg(8'h85, 8'hFF);
    wreg(8'h86, 8'hFF);
    wreg(8'h87, 8'hFF);
    wreg(8'h83, 8'hFF);
    rreg(8'h84, 8'h7F, "mcast");
    rreg(8'h85, 8'h3F, "vid");
    rreg(8'h86, 8'h7F, "self");
    rreg(8'h87, 8'h3C, "rate");
    chk("qmode", 8'h01, {7'h00, qm});
    rreg(8'h83, 8'h00, "unmapped");
    $display("t_rsv done");
  endtask
  // special forwarding maps, their enables and zero maps
  task t_fwd;
    wreg(8'h86, 8'h00);
    wreg(8'h85, 8'h03);
    query(3'b001, 48'h0000_0000_0000, 5'h0A);
    wreg(8'h85, 8'h23);
    query(3'b111, 48'h0000_0000_0000, 5'h03);
    wreg(8'h85, 8'h20);
    query(3'b001, 48'h0000_0000_0000, 5'h00);
    wreg(8'h85, 8'h00);
    wreg(8'h84, 8'h21);
    query(3'b100, 48'h0000_0000_0000, 5'h01);
    query(3'b110, 48'h0000_0000_0000, 5'h0A);
    wreg(8'h86, 8'h2F);
    query(3'b110, 48'h0000_0000_0000, 5'h0F);
    wreg(8'h86, 8'h0F);
    query(3'b110, 48'h0000_0000_0000, 5'h0A);
    wreg(8'h84, 8'h3F);
    query(3'b100, 48'h0000_0000_0000, 5'h1F);
    wreg(8'h84, 8'h20);
    query(3'b100, 48'h0000_0000_0000, 5'h00);
    wreg(8'h84, 8'h01);
    query(3'b100, 48'h0000_0000_0000, 5'h0A);
    $display("t_fwd done");
  endtask
  // own address filter
  task t_self;
    wreg(8'h86, 8'h40);
    query(3'b000, mac, 5'h00);
    query(3'b000, mac + 48'h0000_0000_0001, 5'h0A);
    wreg(8'h86, 8'h00);
    query(3'b000, mac, 5'h0A);
    $display("t_self done");
  endtask
  // tag insertion source choice
  task t_tag;
    wreg(8'h87, 8'h10);
    lut <= 5'h1F;
    src <= 3'h2;
    query(3'b000, 48'h0000_0000_0000, 5'h1F);
    chk("tag", 8'h15, {3'h0, tag});
    wreg(8'h87, 8'h14);
    query(3'b000, 48'h0000_0000_0000, 5'h1F);
    chk("tag", 8'h0E, {3'h0, tag});
    wreg(8'h87, 8'h14);
    lut <= 5'h06;
    query(3'b000, 48'h0000_0000_0000, 5'h06);
    chk("tag", 8'h06, {3'h0, tag});
    $display("t_tag done");
  endtask
  // cycles to the next tick, bounded
  task tick_gap(output int n);
    n = 1;
    while (tick !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // window length for every period code
  task t_tick;
    int n;
    for (int c = 0; c < 4; c++) begin
      wreg(8'h87, {2'b00, 2'(c), 4'h0});
      // let the edge settle before looking at the tick
      #1 tick_gap(n);
      @(posedge clk);
      #1 tick_gap(n);
      chk("window", (c == 0) ? 8'd20 : (c == 1) ? 8'd40 : 8'd80, 8'(n));
    end
    $display("t_tick done");
  endtask
  // verdict and end of run
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence, with a second reset mid-run
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rsv;
    t_fwd;
    t_self;
    t_tag;
    t_tick;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    finish_test;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test;
  end
endmodule
